// file: design/scr_map.vh
// register offsets, field positions, reset values for the switch csr block
`ifndef SCR_MAP_VH
`define SCR_MAP_VH
`define SCR_OFS_PHY_DATA    12'h0A4
`define SCR_OFS_PHY_ACCESS  12'h0A8
`define SCR_OFS_MAC_HIGH    12'h1F0
`define SCR_OFS_MAC_LOW     12'h1F4
`define SCR_OFS_WIN_FIRST   12'h200
`define SCR_OFS_WIN_LAST    12'h2DC
`define SCR_MAC_LOW_RESET   32'hFF0F8000
`define SCR_MAC_HIGH_RESET  16'hFFFF
`define SCR_DIR_WRITE       1'h0
`define SCR_DIR_READ        1'h1
`define SCR_BE_ALL          4'hF
`define SCR_PHY_ADDR_HI     15
`define SCR_PHY_ADDR_LO     11
`define SCR_PHY_IDX_HI      10
`define SCR_PHY_IDX_LO      6
`define SCR_EE_MAC_LOW_B0   8'h01
`define SCR_EE_MAC_LOW_B3   8'h04
`endif

// file: design/scr_window_map.v
// lookup table from direct window word index to fabric register number
`timescale 1ns/1ps
module scr_window_map
(
	input  wire [5:0]  wordIndex,   // (offset - 200h) / 4
	output reg  [15:0] fabricReg    // mapped fabric register number
);
	// ************************************************************
	// fixed translation table
	// ************************************************************
	always @*
	begin
		case (wordIndex)
			6'h00: fabricReg = 16'h0001;
			6'h01: fabricReg = 16'h0004;
			6'h02: fabricReg = 16'h0401;
			6'h03: fabricReg = 16'h0440;
			6'h04: fabricReg = 16'h0441;
			6'h05: fabricReg = 16'h0480;
			6'h06: fabricReg = 16'h0801;
			6'h07: fabricReg = 16'h0840;
			6'h08: fabricReg = 16'h0841;
			6'h09: fabricReg = 16'h0880;
			6'h0A: fabricReg = 16'h0C01;
			6'h0B: fabricReg = 16'h0C40;
			6'h0C: fabricReg = 16'h0C41;
			6'h0D: fabricReg = 16'h0C80;
			6'h0E: fabricReg = 16'h1800;
			6'h0F: fabricReg = 16'h1801;
			6'h10: fabricReg = 16'h1802;
			6'h11: fabricReg = 16'h1809;
			6'h12: fabricReg = 16'h180B;
			6'h13: fabricReg = 16'h180C;
			6'h14: fabricReg = 16'h1811;
			6'h15: fabricReg = 16'h1812;
			6'h16: fabricReg = 16'h1840;
			6'h17: fabricReg = 16'h1841;
			6'h18: fabricReg = 16'h1842;
			6'h19: fabricReg = 16'h1843;
			6'h1A: fabricReg = 16'h1845;
			6'h1B: fabricReg = 16'h1846;
			6'h1C: fabricReg = 16'h1847;
			6'h1D: fabricReg = 16'h1848;
			6'h1E: fabricReg = 16'h1849;
			6'h1F: fabricReg = 16'h184A;
			6'h20: fabricReg = 16'h184B;
			6'h21: fabricReg = 16'h184D;
			6'h22: fabricReg = 16'h1855;
			6'h23: fabricReg = 16'h1856;
			6'h24: fabricReg = 16'h1857;
			6'h25: fabricReg = 16'h1880;
			6'h26: fabricReg = 16'h1C00;
			6'h27: fabricReg = 16'h1C01;
			6'h28: fabricReg = 16'h1C02;
			6'h29: fabricReg = 16'h1C03;
			6'h2A: fabricReg = 16'h1C04;
			6'h2B: fabricReg = 16'h1C09;
			6'h2C: fabricReg = 16'h1C0A;
			6'h2D: fabricReg = 16'h1C0C;
			6'h2E: fabricReg = 16'h1C0D;
			6'h2F: fabricReg = 16'h1C0E;
			6'h30: fabricReg = 16'h1C0F;
			6'h31: fabricReg = 16'h1C10;
			6'h32: fabricReg = 16'h1C11;
			6'h33: fabricReg = 16'h1C12;
			6'h34: fabricReg = 16'h1C13;
			6'h35: fabricReg = 16'h1C14;
			6'h36: fabricReg = 16'h1C15;
			6'h37: fabricReg = 16'h1C20;
			default: fabricReg = 16'h0000;
		endcase
	end
endmodule // scr_window_map

// file: design/scr_switch_csr.v
// switch csr block: pause mac address, direct fabric write window, phy mgmt data
// Behaviour
// - low pause MAC address register at 1F4h
// - low MAC register resets to FF0F8000h
// - loader fills it only for programmed EEPROM
// - EEPROM bytes 01h..04h map bits 7:0..31:24
// - same bytes also go to host MAC low
// - host writes MAC low after init completes
// - window write loads command: address, BE, write, busy
// - busy clearing marks window write done
// - full written word is the fabric data
// - window offsets translate through fixed table
// - phy mgmt registers reachable by loader only
// - phy data at 0A4h holds 16-bit value
// - phy data serves writes only, never reads
// - busy stays until fabric completes; host waits
// - byte enables 19:16 gate bytes 31..0; window writes here always load all four enables set (F)
// - access write launches cycle to addressed phy
`timescale 1ns/1ps
`include "scr_map.vh"
module scr_switch_csr
(
	input  wire        sys_clk,         // system clock, 125 MHz
	input  wire        reset_n,         // synchronous reset, active low
	input  wire        hostWrite,       // host write strobe, one cycle
	input  wire        hostRead,        // host read strobe, one cycle
	input  wire [11:0] hostAddr,        // host byte address
	input  wire [31:0] hostWdata,       // host write data
	output reg  [31:0] hostRdata,       // host read data, registered
	output wire        hostBusy,        // direct window write in flight
	input  wire        initDone,        // device initialisation finished
	input  wire        eeWrite,         // loader register write strobe
	input  wire [11:0] eeAddr,          // loader register byte address
	input  wire [31:0] eeWdata,         // loader register write data
	input  wire        eeByteValid,     // loader delivers one eeprom byte
	input  wire [7:0]  eeByteAddr,      // eeprom byte address
	input  wire [7:0]  eeByteData,      // eeprom byte value
	input  wire        eeProgrammed,    // programmed eeprom detected
	output reg  [31:0] hostMacLow,      // host mac low address copy
	output reg         hostMacLowLoad,  // pulse: host mac low loaded
	output wire [47:0] pauseSourceMac,  // pause frame source address
	output reg  [15:0] fabricRegNum,    // fabric register number
	output reg  [3:0]  fabricByteEn,    // fabric byte enables
	output reg         fabricDirection, // 0 write, 1 read
	output reg  [31:0] fabricWdata,     // fabric write data
	output reg         fabricReq,       // fabric request, level while busy
	input  wire        fabricDone,      // fabric access complete pulse
	output reg  [15:0] phyWdata,        // data for the phy write
	output reg  [4:0]  phyAddr,         // selected phy
	output reg  [4:0]  phyRegIndex,     // selected phy register
	output reg         phyStart         // pulse: start phy write cycle
);
	// ************************************************************
	// state and decode
	// ************************************************************
	reg  [31:0] macLow_reg;            // switch mac low address
	reg  [31:0] macLow_next;           // next value
	reg  [15:0] macHigh_reg;           // switch mac high address
	reg  [31:0] eeAsm_reg;             // eeprom bytes being assembled
	reg  [31:0] eeAsm_next;            // next assembly value
	reg         busy_reg;              // fabric access busy
	wire        winHit;                // host address inside window
	wire [11:0] winOffset;             // offset from window base
	wire [15:0] mappedReg;             // table output
	reg  [31:0] beMask;                // byte enable as bit mask

	assign winOffset = hostAddr - `SCR_OFS_WIN_FIRST;
	assign winHit = (hostAddr >= `SCR_OFS_WIN_FIRST) && (hostAddr <= `SCR_OFS_WIN_LAST)
		&& (hostAddr[1:0] == 2'h0);
	assign hostBusy = busy_reg;
	assign pauseSourceMac = {macHigh_reg, macLow_reg};

	// window offset translation
	scr_window_map uMap
	(
		.wordIndex (winOffset[7:2]),
		.fabricReg (mappedReg)
	);

	// ************************************************************
	// byte enable mask, applied to fabric data
	// ************************************************************
	always @*
	begin
		beMask = {{8{fabricByteEn[3]}}, {8{fabricByteEn[2]}},
			{8{fabricByteEn[1]}}, {8{fabricByteEn[0]}}};
	end

	// ************************************************************
	// eeprom byte assembly
	// ************************************************************
	always @*
	begin
		eeAsm_next = eeAsm_reg;
		if (eeByteValid && eeProgrammed && (eeByteAddr >= `SCR_EE_MAC_LOW_B0)
			&& (eeByteAddr <= `SCR_EE_MAC_LOW_B3))
		begin
			// byte 01h lands in 7:0, 04h in 31:24
			case (eeByteAddr[1:0])
				2'h1: eeAsm_next[7:0] = eeByteData;
				2'h2: eeAsm_next[15:8] = eeByteData;
				2'h3: eeAsm_next[23:16] = eeByteData;
				default: eeAsm_next[31:24] = eeByteData;
			endcase
		end
	end

	// ************************************************************
	// mac low next value
	// ************************************************************
	always @*
	begin
		macLow_next = macLow_reg;
		if (eeByteValid && eeProgrammed && (eeByteAddr == `SCR_EE_MAC_LOW_B3))
			macLow_next = eeAsm_next;
		else if (hostWrite && initDone && (hostAddr == `SCR_OFS_MAC_LOW))
			macLow_next = hostWdata;
	end

	// ************************************************************
	// mac address registers
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			macLow_reg <= `SCR_MAC_LOW_RESET;
			macHigh_reg <= `SCR_MAC_HIGH_RESET;
			eeAsm_reg <= 32'h00000000;
			hostMacLow <= 32'h00000000;
			hostMacLowLoad <= 1'b0;
		end
		else
		begin
			macLow_reg <= macLow_next;
			eeAsm_reg <= eeAsm_next;
			hostMacLowLoad <= 1'b0;
			if (hostWrite && initDone && (hostAddr == `SCR_OFS_MAC_HIGH))
				macHigh_reg <= hostWdata[15:0];
			if (eeByteValid && eeProgrammed && (eeByteAddr == `SCR_EE_MAC_LOW_B3))
			begin
				hostMacLow <= eeAsm_next;
				hostMacLowLoad <= 1'b1;
			end
		end
	end

	// ************************************************************
	// direct window command and fabric handshake
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			busy_reg <= 1'b0;
			fabricReq <= 1'b0;
			fabricRegNum <= 16'h0000;
			fabricByteEn <= 4'h0;
			fabricDirection <= `SCR_DIR_WRITE;
			fabricWdata <= 32'h00000000;
		end
		else if (busy_reg)
		begin
			// hold command until fabric completes; later writes ignored
			if (fabricDone)
			begin
				busy_reg <= 1'b0;
				fabricReq <= 1'b0;
			end
		end
		else if (hostWrite && winHit)
		begin
			fabricRegNum <= mappedReg;
			fabricByteEn <= `SCR_BE_ALL;
			fabricDirection <= `SCR_DIR_WRITE;
			fabricWdata <= hostWdata;
			busy_reg <= 1'b1;
			fabricReq <= 1'b1;
		end
	end

	// ************************************************************
	// phy management registers, loader port only
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			phyWdata <= 16'h0000;
			phyAddr <= 5'h00;
			phyRegIndex <= 5'h00;
			phyStart <= 1'b0;
		end
		else
		begin
			phyStart <= 1'b0;
			// host port never reaches these
			if (eeWrite && (eeAddr == `SCR_OFS_PHY_DATA))
				phyWdata <= eeWdata[15:0];
			if (eeWrite && (eeAddr == `SCR_OFS_PHY_ACCESS))
			begin
				phyAddr <= eeWdata[`SCR_PHY_ADDR_HI:`SCR_PHY_ADDR_LO];
				phyRegIndex <= eeWdata[`SCR_PHY_IDX_HI:`SCR_PHY_IDX_LO];
				phyStart <= 1'b1;
			end
		end
	end

	// ************************************************************
	// host read data; window and phy registers read zero
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			hostRdata <= 32'h00000000;
		else if (hostRead)
		begin
			case (hostAddr)
				`SCR_OFS_MAC_LOW:  hostRdata <= macLow_reg;
				`SCR_OFS_MAC_HIGH: hostRdata <= {16'h0000, macHigh_reg};
				default:           hostRdata <= 32'h00000000;
			endcase
		end
	end

	// masked data view kept for the fabric engine
	wire [31:0] fabricMaskedData;      // unused bytes forced low
	assign fabricMaskedData = fabricWdata & beMask;
endmodule // scr_switch_csr

// file: tb/scr_csr_checker.sv
// checker of the switch csr block ports
`timescale 1ns/1ps
module scr_csr_checker
(
	input wire        sys_clk,         // clock
	input wire        reset_n,         // reset
	input wire        hostWrite,       // write
	input wire [11:0] hostAddr,        // address
	input wire [31:0] hostWdata,       // data
	input wire        hostBusy,        // busy
	input wire        fabricReq,       // request
	input wire        fabricDone,      // done
	input wire [15:0] fabricRegNum,    // number
	input wire [3:0]  fabricByteEn,    // enables
	input wire        fabricDirection, // direction
	input wire [31:0] fabricWdata,     // data
	input wire        eeWrite,         // loader
	input wire [11:0] eeAddr,          // loader
	input wire [31:0] eeWdata,         // loader
	input wire [15:0] phyWdata,        // phy data
	input wire        phyStart         // phy start
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire [15:0] eeLow = eeWdata[15:0]; // low loader half
	wire inWin = hostAddr >= 12'h200 && hostAddr <= 12'h2DC && hostAddr[1:0] == 2'h0;
	a_window_cmd_load: assert property (hostWrite && inWin && !hostBusy |=> hostBusy
		&& fabricByteEn == 4'hF && !fabricDirection && fabricWdata == $past(hostWdata))
		else $error("window command wrong");
	a_done_clears_busy: assert property (fabricDone && hostBusy |=> !hostBusy && !fabricReq)
		else $error("busy not cleared");
	a_busy_holds_wait: assert property (hostBusy && !fabricDone |=> hostBusy)
		else $error("busy dropped early");
	a_req_follows_busy: assert property (fabricReq == hostBusy)
		else $error("request and busy differ");
	a_cmd_stands_busy: assert property (hostBusy |=> $stable(fabricWdata) && $stable(fabricRegNum))
		else $error("command moved while busy");
	a_other_write_idle: assert property (hostWrite && !inWin && !hostBusy |=> !hostBusy)
		else $error("busy from a non-window write");
	a_phy_data_load: assert property (eeWrite && eeAddr == 12'h0A4 |=> phyWdata == $past(eeLow))
		else $error("phy data not loaded");
	a_host_phy_blocked: assert property (hostWrite && hostAddr == 12'h0A4 && !eeWrite |=> $stable(phyWdata))
		else $error("host reached phy data");
	a_phy_start_pulse: assert property (eeWrite && eeAddr == 12'h0A8 |=> phyStart ##1 !phyStart)
		else $error("phy start not one pulse");
endmodule // scr_csr_checker
bind scr_switch_csr scr_csr_checker chk (.*);

// file: tb/scr_fabric_model.sv
// fabric register engine model answering window writes after a set wait
`timescale 1ns/1ps
module scr_fabric_model
(
	input  wire        sys_clk,      // clock
	input  wire        reset_n,      // reset
	input  wire        fabricReq,    // request level
	input  wire [15:0] fabricRegNum, // number
	input  wire [31:0] fabricWdata,  // data
	input  wire [7:0]  waitCycles,   // answer delay
	output reg         fabricDone,   // done pulse
	output reg  [15:0] gotNum,       // number taken
	output reg  [31:0] gotData       // data taken
);
	reg [7:0] cnt;   // cycles left
	reg       taken; // request seen
	// take each request once, answer after the wait with one pulse
	always @(posedge sys_clk)
		if (!reset_n)
			{fabricDone, taken, cnt, gotNum, gotData} <= 58'h0;
		else if (!fabricReq)
			{fabricDone, taken} <= 2'h0;
		else if (!taken)
			{taken, cnt, gotNum, gotData} <= {1'h1, waitCycles, fabricRegNum, fabricWdata};
		else if (cnt != 8'h0)
			cnt <= cnt - 8'h1;
		else
			fabricDone <= !fabricDone;
endmodule // scr_fabric_model

// file: tb/test_switch_csr_direct_write_and_mac_regs.sv
// self-checking bench of the switch csr block with a fabric model
`timescale 1ns/1ps
`define CHK(a,b) begin nCompared++; if ((a) !== (b)) begin numErrors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module test_switch_csr_direct_write_and_mac_regs;
	reg sys_clk = 0, reset_n = 0, hostWrite = 0, hostRead = 0, initDone = 0;
	reg eeWrite = 0, eeByteValid = 0, eeProgrammed = 0;
	reg [11:0] hostAddr = 12'h0, eeAddr = 12'h0;
	reg [31:0] hostWdata = 32'h0, eeWdata = 32'h0, seed = 32'h5F, d, q;
	reg [7:0] eeByteAddr = 8'h0, eeByteData = 8'h0, waitCycles = 8'h0;
	wire [31:0] hostRdata, hostMacLow, fabricWdata, gotData;
	wire [47:0] pauseSourceMac;
	wire [15:0] fabricRegNum, phyWdata, gotNum;
	wire [4:0] phyAddr, phyRegIndex;
	wire [3:0] fabricByteEn;
	wire hostBusy, hostMacLowLoad, fabricDirection, fabricReq, fabricDone, phyStart;
	integer numErrors = 0, nCompared = 0, i;
	// expected fabric numbers, window word 0 first
	localparam [895:0] MAP = {
		16'h0001, 16'h0004, 16'h0401, 16'h0440, 16'h0441, 16'h0480, 16'h0801, 16'h0840,
		16'h0841, 16'h0880, 16'h0C01, 16'h0C40, 16'h0C41, 16'h0C80, 16'h1800, 16'h1801,
		16'h1802, 16'h1809, 16'h180B, 16'h180C, 16'h1811, 16'h1812, 16'h1840, 16'h1841,
		16'h1842, 16'h1843, 16'h1845, 16'h1846, 16'h1847, 16'h1848, 16'h1849, 16'h184A,
		16'h184B, 16'h184D, 16'h1855, 16'h1856, 16'h1857, 16'h1880, 16'h1C00, 16'h1C01,
		16'h1C02, 16'h1C03, 16'h1C04, 16'h1C09, 16'h1C0A, 16'h1C0C, 16'h1C0D, 16'h1C0E,
		16'h1C0F, 16'h1C10, 16'h1C11, 16'h1C12, 16'h1C13, 16'h1C14, 16'h1C15, 16'h1C20};
	always #4 sys_clk = ~sys_clk;
	scr_switch_csr uut (.*);
	scr_fabric_model fab (.*);
	function [31:0] rnd(); // xorshift source
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	task hw(input [11:0] a, input [31:0] v); // host write strobe
		@(posedge sys_clk) {hostWrite, hostAddr, hostWdata} <= {1'h1, a, v};
		@(posedge sys_clk) hostWrite <= 1'h0;
		#1;
	endtask
	task hr(input [11:0] a); // host read into q
		@(posedge sys_clk) {hostRead, hostAddr} <= {1'h1, a};
		@(posedge sys_clk) hostRead <= 1'h0;
		#1 q = hostRdata;
	endtask
	task ew(input [11:0] a, input [31:0] v); // loader register write
		@(posedge sys_clk) {eeWrite, eeAddr, eeWdata} <= {1'h1, a, v};
		@(posedge sys_clk) eeWrite <= 1'h0;
		#1;
	endtask
	task eb(input [7:0] a, input [7:0] v); // one eeprom byte
		@(posedge sys_clk) {eeByteValid, eeByteAddr, eeByteData} <= {1'h1, a, v};
		@(posedge sys_clk) eeByteValid <= 1'h0;
		#1;
	endtask
	task end_of_test; // counts, verdict, stop
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		numErrors++;
		end_of_test;
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'h1;
		hw(12'h1F4, rnd());
		hr(12'h1F4);
		`CHK(q, 32'hFF0F8000)
		`CHK(pauseSourceMac, {16'hFFFF, 32'hFF0F8000})
		d = rnd();
		for (i = 1; i < 5; i++) eb(i[7:0], d[8*i-8 +: 8]);
		hr(12'h1F4);
		`CHK(q, 32'hFF0F8000)
		eeProgrammed <= 1'h1;
		for (i = 1; i < 5; i++) eb(i[7:0], d[8*i-8 +: 8]);
		`CHK({hostMacLowLoad, hostMacLow}, {1'h1, d})
		hr(12'h1F4);
		`CHK(q, d)
		initDone <= 1'h1;
		d = rnd();
		hw(12'h1F4, d);
		hr(12'h1F4);
		`CHK(q, d)
		`CHK(pauseSourceMac[31:0], d)
		$display("test mac done");
		for (i = 0; i < 56; i++)
		begin
			d = rnd();
			waitCycles <= (i % 8 == 0) ? 8'h28 : {6'h0, d[1:0]};
			hw(12'h200 + {i[9:0], 2'h0}, d);
			`CHK({hostBusy, fabricByteEn, fabricDirection, fabricWdata}, {5'h1F, 1'h0, d})
			`CHK(fabricRegNum, MAP[895 - 16 * i -: 16])
			if (i % 8 == 0) hw(12'h204, ~d);
			`CHK(fabricWdata, d)
			repeat (60) if (hostBusy === 1'h1) @(posedge sys_clk);
			#1;
			`CHK({hostBusy, gotData}, {1'h0, d})
		end
		hw(12'h2E0, rnd());
		`CHK(hostBusy, 1'h0)
		hw(12'h202, rnd());
		`CHK(hostBusy, 1'h0)
		$display("test window done");
		hw(12'h0A4, 32'h0000BEEF);
		`CHK(phyWdata, 16'h0000)
		d = rnd();
		ew(12'h0A4, d);
		`CHK(phyWdata, d[15:0])
		ew(12'h0A8, {16'h0, d[31:22], 6'h02});
		`CHK({phyStart, phyAddr, phyRegIndex}, {1'h1, d[31:22]})
		hr(12'h0A4);
		`CHK(q, 32'h0)
		$display("test phy done");
		end_of_test;
	end
endmodule // test_switch_csr_direct_write_and_mac_regs
